// ==== src/pscc_ctrl.sv ====
// Functional notes
// (RQ1) idle freezes pc, no fetch, state kept
// (RQ2) idle keeps all clocks; any irq wakes
// (RQ3) power_control bit0 write enters idle
// (RQ4) idle irq vectors, clears idle bit
// (RQ5) any reset clears idle, holds core
// (RQ6) watchdog keeps counting during idle
// (RQ7) power_control bit1 halts clocks and crystal
// (RQ8) stop wins over idle when both set
// (RQ9) only nonclocked interrupts end stop
// (RQ10) power-fail wakes stop only with bandgap
// (RQ11) reset pin ends stop; no watchdog reset
// (RQ12) brownout resets in stop only with bandgap
// (RQ13) ale and fetch strobe high when saving
// (RQ14) external idle ports keep latched bus
// (RQ15) ring select restarts from ring oscillator
// (RQ16) switch to crystal after 65536 clocks
// (RQ17) re-stop before settle stops both oscillators
// (RQ18) divider: 00 mult,01 rsvd,10 one,11 slow
// (RQ19) divider leaves 10 only from 10
// (RQ20) switchback forces divide-by-1 when enabled
// (RQ21) status 7:5 shows active irq level
// (RQ22) status 3:0 shows serial activity
module pscc_ctrl #(
  parameter int XTAL_SETTLE = pscc_pkg::XTAL_SETTLE_CYC
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic ext_wake_i,
  input wire logic pfail_wake_i,
  input wire logic any_irq_i,
  input wire logic ext_irq_ack_i,
  input wire logic ext_reset_pin_i,
  input wire logic brownout_i,
  input wire logic por_i,
  input wire logic wdt_reset_i,
  input wire logic [2:0] active_irq_level_i,
  input wire logic [3:0] ser_active_i,
  input wire logic ser_rx_fall_i,
  input wire logic ser_tx_load_i,
  input wire logic xtal_tick_i,
  input wire logic ext_exec_i,
  output logic core_hold_o,
  output logic core_reset_o,
  output logic clocks_run_o,
  output logic xtal_amp_en_o,
  output logic ring_osc_en_o,
  output logic ring_clk_sel_o,
  output logic [1:0] divider_sel_o,
  output logic addr_latch_en_o,
  output logic program_fetch_strobe_o,
  output logic port0_open_drain_o,
  output logic port2_weak_pull_o,
  output logic port_bus_hold_o
);

  // -----------------------------------------------------------------
  // decode helpers
  // -----------------------------------------------------------------
  // a write lands in its data phase, against the address held from the address phase
  function automatic logic wr_hit(input logic ap, input logic wr, input logic [7:0] ap_addr,
                                  input logic [7:0] reg_addr);
    return ap && wr && (ap_addr == reg_addr);
  endfunction

  // leaving divide-by-one or returning to it are the only legal moves
  function automatic logic div_move_ok(input logic [1:0] cur, input logic [1:0] req);
    return (req == pscc_pkg::DIV_ONE) || (cur == pscc_pkg::DIV_ONE);
  endfunction

  // -----------------------------------------------------------------
  // pin synchronisers: three stages, change once stages 2 and 3 agree
  // -----------------------------------------------------------------
  localparam int NPIN = 5;
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_s1_r;
  logic [NPIN-1:0] pin_s2_r;
  logic [NPIN-1:0] pin_s3_r;
  logic [NPIN-1:0] pin_q_r;
  logic ext_wake;
  logic pfail_wake;
  logic rst_pin;
  logic brownout;
  logic por;

  assign pin_raw = {ext_wake_i, pfail_wake_i, ext_reset_pin_i, brownout_i, por_i};

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
      pin_s3_r <= '0;
      pin_q_r <= '0;
    end else begin
      pin_s1_r <= pin_raw;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
      for (int i = 0; i < NPIN; i++) begin
        if (pin_s2_r[i] == pin_s3_r[i]) begin
          pin_q_r[i] <= pin_s3_r[i];
        end
      end
    end
  end

  assign {ext_wake, pfail_wake, rst_pin, brownout, por} = pin_q_r;

  // -----------------------------------------------------------------
  // ahb-lite slave, zero wait states
  // -----------------------------------------------------------------
  logic ap_r;
  logic ap_wr_r;
  logic [7:0] ap_addr_r;
  logic take;
  logic wr_power_control;
  logic wr_pmr;
  logic wr_cfg;

  assign take = hsel_i && htrans_i[1] && hready_i;
  assign wr_power_control = wr_hit(ap_r, ap_wr_r, ap_addr_r, pscc_pkg::ADDR_POWER_CONTROL);
  assign wr_pmr = wr_hit(ap_r, ap_wr_r, ap_addr_r, pscc_pkg::ADDR_POWER_MGMT);
  assign wr_cfg = wr_hit(ap_r, ap_wr_r, ap_addr_r, pscc_pkg::ADDR_WAKE_CONFIG);

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      ap_r <= 1'b0;
      ap_wr_r <= 1'b0;
      ap_addr_r <= 8'h00;
    end else begin
      ap_r <= take;
      ap_wr_r <= hwrite_i;
      ap_addr_r <= haddr_i[7:0];
    end
  end

  // -----------------------------------------------------------------
  // reset sources
  // -----------------------------------------------------------------
  pscc_pkg::pscc_state_e state_r;
  pscc_pkg::pscc_state_e state_nxt;
  logic bgs_r;
  logic ring_sel_r;
  logic in_stop;
  logic any_reset;

  assign in_stop = (state_r == pscc_pkg::PSCC_STOP);
  // watchdog is frozen in stop, brownout needs the bandgap there
  assign any_reset = por || rst_pin                                  // [RQ11] [RQ5]
                  || (wdt_reset_i && !in_stop)                       // [RQ11]
                  || (brownout && (!in_stop || bgs_r));              // [RQ12]

  // -----------------------------------------------------------------
  // power state machine
  // -----------------------------------------------------------------
  logic [1:0] power_control_r;
  logic stop_wake;

  // only nonclocked sources; power fail counts only with bandgap on
  assign stop_wake = ext_wake || (pfail_wake && bgs_r);              // [RQ9] [RQ10]

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      pscc_pkg::PSCC_RUN: begin
        if (wr_power_control && hwdata_i[pscc_pkg::POS_STOP]) begin
          state_nxt = pscc_pkg::PSCC_STOP;                           // [RQ7] [RQ8]
        end else if (wr_power_control && hwdata_i[pscc_pkg::POS_IDLE]) begin
          state_nxt = pscc_pkg::PSCC_IDLE;                           // [RQ3]
        end
      end
      pscc_pkg::PSCC_IDLE: begin
        if (any_irq_i) begin
          state_nxt = pscc_pkg::PSCC_RUN;                            // [RQ2] [RQ4]
        end
      end
      pscc_pkg::PSCC_STOP: begin
        if (stop_wake) begin
          state_nxt = pscc_pkg::PSCC_RUN;                            // [RQ9]
        end
      end
      default: state_nxt = pscc_pkg::PSCC_RUN;
    endcase
    // a reset source overrides any pending move so every output sees run together
    if (any_reset) begin
      state_nxt = pscc_pkg::PSCC_RUN;                                // [RQ5]
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      state_r <= pscc_pkg::PSCC_RUN;
    end else if (any_reset) begin
      state_r <= pscc_pkg::PSCC_RUN;                                 // [RQ5]
    end else begin
      state_r <= state_nxt;
    end
  end

  // power_control bits mirror the state; wake clears them
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i || any_reset) begin
      power_control_r <= pscc_pkg::RST_POWER_CONTROL;
    end else begin
      power_control_r[pscc_pkg::POS_IDLE] <= (state_nxt == pscc_pkg::PSCC_IDLE);   // [RQ4]
      power_control_r[pscc_pkg::POS_STOP] <= (state_nxt == pscc_pkg::PSCC_STOP);
    end
  end

  // -----------------------------------------------------------------
  // wake configuration (ring select survives all but power-on)
  // -----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i || por) begin
      ring_sel_r <= 1'b0;
      bgs_r <= 1'b0;
    end else if (wr_cfg) begin
      ring_sel_r <= hwdata_i[pscc_pkg::POS_RING_SEL];
      bgs_r <= hwdata_i[pscc_pkg::POS_BGS];
    end
  end

  // -----------------------------------------------------------------
  // oscillator control: ring restart and crystal settle count
  // -----------------------------------------------------------------
  logic on_ring_r;
  logic [16:0] settle_r;
  logic waking;

  assign waking = in_stop && (state_nxt == pscc_pkg::PSCC_RUN) && !any_reset;

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i || any_reset) begin
      on_ring_r <= 1'b0;
      settle_r <= '0;
    end else if (state_nxt == pscc_pkg::PSCC_STOP) begin
      on_ring_r <= 1'b0;                                             // [RQ17]
      settle_r <= '0;
    end else if (waking) begin
      on_ring_r <= ring_sel_r;                                       // [RQ15]
      settle_r <= '0;
    end else if (on_ring_r && xtal_tick_i) begin
      if (settle_r == 17'(XTAL_SETTLE - 1)) begin
        on_ring_r <= 1'b0;                                           // [RQ16]
      end else begin
        settle_r <= settle_r + 17'h00001;
      end
    end
  end

  // -----------------------------------------------------------------
  // clock divider with switchback
  // -----------------------------------------------------------------
  logic [1:0] divider_r;
  logic swb_r;
  logic [1:0] div_wr;
  logic switchback;

  assign div_wr = hwdata_i[pscc_pkg::POS_DIV_LO +: 2];
  assign switchback = swb_r && (divider_r == pscc_pkg::DIV_SLOW)
                   && (ext_irq_ack_i || ser_rx_fall_i || ser_tx_load_i);   // [RQ20]

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i || any_reset) begin
      divider_r <= pscc_pkg::RST_DIVIDER;                            // [RQ18]
      swb_r <= pscc_pkg::RST_SWB;
    end else begin
      if (wr_pmr) begin
        swb_r <= hwdata_i[pscc_pkg::POS_SWB];
      end
      // hardware switchback beats a concurrent software write
      if (switchback) begin
        divider_r <= pscc_pkg::DIV_ONE;                              // [RQ20]
      end else if (wr_pmr && div_move_ok(divider_r, div_wr)) begin
        divider_r <= div_wr;                                         // [RQ19]
      end
    end
  end

  // -----------------------------------------------------------------
  // read data
  // -----------------------------------------------------------------
  logic [7:0] rd_nxt;
  pscc_pkg::pscc_ser_s ser_st;

  assign ser_st = ser_active_i;

  always_comb begin
    rd_nxt = 8'h00;
    case (haddr_i[7:0])
      pscc_pkg::ADDR_POWER_CONTROL: rd_nxt = {6'h00, power_control_r};
      pscc_pkg::ADDR_POWER_MGMT: rd_nxt = {divider_r, swb_r, 5'h00};
      pscc_pkg::ADDR_POWER_STATUS: begin
        rd_nxt = {active_irq_level_i, 1'b0, ser_st};                 // [RQ21] [RQ22]
      end
      pscc_pkg::ADDR_WAKE_CONFIG: rd_nxt = {6'h00, bgs_r, ring_sel_r};
      pscc_pkg::ADDR_CORE_STATE: rd_nxt = {5'h00, on_ring_r, state_r};
      default: rd_nxt = 8'h00;
    endcase
  end

  // launched in the address phase so the word stands through the data phase
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      hrdata_o <= 32'h00000000;
    end else if (take && !hwrite_i) begin
      hrdata_o <= {24'h000000, rd_nxt};
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end else begin
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end
  end

  // -----------------------------------------------------------------
  // core, clock and pin outputs
  // -----------------------------------------------------------------
  logic saving;
  logic ring_nxt;

  assign saving = (state_nxt != pscc_pkg::PSCC_RUN);
  // follows the oscillator's next state, so stopping silences the ring in the same cycle
  assign ring_nxt = !any_reset && (state_nxt != pscc_pkg::PSCC_STOP)
                 && (on_ring_r || (waking && ring_sel_r));

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      core_hold_o <= 1'b0;
      core_reset_o <= 1'b1;
      clocks_run_o <= 1'b1;
      xtal_amp_en_o <= 1'b1;
      ring_osc_en_o <= 1'b0;
      ring_clk_sel_o <= 1'b0;
      divider_sel_o <= pscc_pkg::RST_DIVIDER;
      addr_latch_en_o <= 1'b1;
      program_fetch_strobe_o <= 1'b1;
      port0_open_drain_o <= 1'b0;
      port2_weak_pull_o <= 1'b0;
      port_bus_hold_o <= 1'b0;
    end else begin
      // pc frozen, no fetch; watchdog clocks untouched in idle
      core_hold_o <= saving && !any_reset;                           // [RQ1] [RQ6]
      core_reset_o <= any_reset;                                     // [RQ5] [RQ12]
      clocks_run_o <= (state_nxt != pscc_pkg::PSCC_STOP);           // [RQ2] [RQ7]
      xtal_amp_en_o <= (state_nxt != pscc_pkg::PSCC_STOP);          // [RQ7]
      ring_osc_en_o <= ring_nxt;                                     // [RQ17]
      ring_clk_sel_o <= ring_nxt;                                    // [RQ15]
      divider_sel_o <= divider_r;
      addr_latch_en_o <= 1'b1;                                       // [RQ13]
      program_fetch_strobe_o <= 1'b1;                                // [RQ13]
      port0_open_drain_o <= saving && (!ext_exec_i || state_nxt == pscc_pkg::PSCC_STOP); // [RQ13]
      port2_weak_pull_o <= (state_nxt == pscc_pkg::PSCC_STOP);       // [RQ14]
      port_bus_hold_o <= ext_exec_i && (state_nxt == pscc_pkg::PSCC_IDLE);   // [RQ14]
    end
  end

endmodule // pscc_ctrl

// ==== src/pscc_pkg.sv ====
package pscc_pkg;
  // -----------------------------------------------------------------
  // register map (byte addresses on the bus)
  // -----------------------------------------------------------------
  localparam logic [7:0] ADDR_POWER_CONTROL = 8'h87;
  localparam logic [7:0] ADDR_POWER_MGMT = 8'hC4;
  localparam logic [7:0] ADDR_POWER_STATUS = 8'hC5;
  localparam logic [7:0] ADDR_WAKE_CONFIG = 8'hC8;
  localparam logic [7:0] ADDR_CORE_STATE = 8'hCC;

  // -----------------------------------------------------------------
  // field positions
  // -----------------------------------------------------------------
  localparam int POS_IDLE = 0;
  localparam int POS_STOP = 1;
  localparam int POS_DIV_LO = 6;
  localparam int POS_SWB = 5;
  localparam int POS_RING_SEL = 0;
  localparam int POS_BGS = 1;
  localparam int POS_LEVEL_LO = 5;

  // -----------------------------------------------------------------
  // divider encodings and reset values
  // -----------------------------------------------------------------
  localparam logic [1:0] DIV_MULT = 2'h0;
  localparam logic [1:0] DIV_RSVD = 2'h1;
  localparam logic [1:0] DIV_ONE = 2'h2;
  localparam logic [1:0] DIV_SLOW = 2'h3;
  localparam logic [1:0] RST_DIVIDER = DIV_ONE;
  localparam logic RST_SWB = 1'h0;
  localparam logic [1:0] RST_POWER_CONTROL = 2'h0;
  localparam int SLOW_DIV = 1024;
  localparam int XTAL_SETTLE_CYC = 65536;

  // -----------------------------------------------------------------
  // power state
  // -----------------------------------------------------------------
  typedef enum logic [1:0] {
    PSCC_RUN = 2'b00,
    PSCC_IDLE = 2'b01,
    PSCC_STOP = 2'b10
  } pscc_state_e;

  typedef struct packed {
    logic ext_wake;
    logic pfail_wake;
    logic any_irq;
    logic ext_irq_ack;
  } pscc_irq_s;

  typedef struct packed {
    logic ser1_tx_active;
    logic ser1_rx_active;
    logic ser0_tx_active;
    logic ser0_rx_active;
  } pscc_ser_s;
endpackage

// ==== test/pscc_ctrl_properties.sv ====
module pscc_ctrl_chk #(
  parameter int XTAL_SETTLE = 16
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  input wire logic [31:0] hrdata_o,
  input wire logic ext_wake_i,
  input wire logic pfail_wake_i,
  input wire logic any_irq_i,
  input wire logic ext_reset_pin_i,
  input wire logic brownout_i,
  input wire logic por_i,
  input wire logic [2:0] active_irq_level_i,
  input wire logic [3:0] ser_active_i,
  input wire logic core_hold_o,
  input wire logic core_reset_o,
  input wire logic clocks_run_o,
  input wire logic xtal_amp_en_o,
  input wire logic ring_osc_en_o,
  input wire logic ring_clk_sel_o,
  input wire logic [1:0] divider_sel_o,
  input wire logic addr_latch_en_o,
  input wire logic program_fetch_strobe_o,
  input wire logic port2_weak_pull_o,
  input wire logic port_bus_hold_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------
  // bus phase trackers
  // ---------------------------------------------
  logic take;
  logic wr_pc_r;
  logic rd_st_r;
  logic [2:0] quiet_r;
  assign take = hsel_i && htrans_i[1] && hready_i;
  always_ff @(posedge mclk_i) begin
    wr_pc_r <= rst_n_i && take && hwrite_i && haddr_i[7:0] == pscc_pkg::ADDR_POWER_CONTROL;
    rd_st_r <= rst_n_i && take && !hwrite_i && haddr_i[7:0] == pscc_pkg::ADDR_POWER_STATUS;
  end
  // async wakes pass a synchroniser, so only a long quiet spell proves none is in flight
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i || ext_wake_i || pfail_wake_i || ext_reset_pin_i || por_i || brownout_i) begin
      quiet_r <= 3'h0;
    end else if (quiet_r != 3'h7) begin
      quiet_r <= quiet_r + 3'h1;
    end
  end
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  pins_high_a: assert property (core_hold_o |-> addr_latch_en_o && program_fetch_strobe_o)
    else $error("strobes low while saving");
  stop_osc_a: assert property (!clocks_run_o |-> core_hold_o && !xtal_amp_en_o
    && !ring_osc_en_o) else $error("oscillator alive in stop");
  idle_entry_a: assert property (wr_pc_r && hwdata_i[1:0] == 2'h1
    && clocks_run_o && !any_irq_i |-> ##[1:2] core_hold_o && clocks_run_o)
    else $error("idle not entered");
  stop_entry_a: assert property (wr_pc_r && hwdata_i[1] |-> ##[1:2] !clocks_run_o)
    else $error("stop not entered");
  div_legal_a: assert property ($changed(divider_sel_o) |->
    divider_sel_o == pscc_pkg::DIV_ONE || $past(divider_sel_o) == pscc_pkg::DIV_ONE)
    else $error("divider skipped divide by one");
  status_rd_a: assert property (rd_st_r && $stable(active_irq_level_i)
    && $stable(ser_active_i) |-> hrdata_o[7:5] == active_irq_level_i
    && hrdata_o[3:0] == ser_active_i)
    else $error("status read wrong");
  stop_quiet_a: assert property (!clocks_run_o && quiet_r == 3'h7 |=> !clocks_run_o)
    else $error("stop left without wake");
  pin_reset_a: assert property (ext_reset_pin_i [*8] |-> core_reset_o && !core_hold_o)
    else $error("reset pin ignored");
  ring_run_a: assert property (ring_clk_sel_o |-> ring_osc_en_o && clocks_run_o)
    else $error("ring selected but off");
  bus_hold_a: assert property (port_bus_hold_o |-> core_hold_o && clocks_run_o)
    else $error("bus held outside idle");
  weak_pull_a: assert property (port2_weak_pull_o |-> !clocks_run_o)
    else $error("weak pullups outside stop");
endmodule // pscc_ctrl_chk

bind pscc_ctrl pscc_ctrl_chk #(.XTAL_SETTLE(XTAL_SETTLE)) u_chk (.mclk_i, .rst_n_i, .hsel_i,
  .haddr_i, .htrans_i, .hwrite_i, .hwdata_i, .hready_i, .hrdata_o, .ext_wake_i, .pfail_wake_i,
  .any_irq_i, .ext_reset_pin_i, .brownout_i, .por_i, .active_irq_level_i, .ser_active_i,
  .core_hold_o, .core_reset_o, .clocks_run_o, .xtal_amp_en_o, .ring_osc_en_o, .ring_clk_sel_o,
  .divider_sel_o, .addr_latch_en_o, .program_fetch_strobe_o, .port2_weak_pull_o,
  .port_bus_hold_o);

// ==== test/pscc_core_model.sv ====
module pscc_core_model (
  input wire logic mclk_i,
  input wire logic irq_req_i,
  input wire logic wdt_req_i,
  output logic any_irq_o = 1'b0,
  output logic wdt_reset_o = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  // interrupt logic flags an enabled, pending request one clock after it arrives
  always_ff @(posedge mclk_i) any_irq_o <= irq_req_i;
  // software services the watchdog, so a watchdog reset only comes when forced
  always_ff @(posedge mclk_i) wdt_reset_o <= wdt_req_i;
endmodule // pscc_core_model

// ==== test/tb.sv ====
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_i = 1'b0, rst_n_i = 1'b0, hsel_i = 1'b0, hwrite_i = 1'b0;
  logic [31:0] haddr_i = 32'h0, hwdata_i = 32'h0, hrdata_o;
  logic [1:0] htrans_i = 2'h0, divider_sel_o;
  logic ext_wake_i = 1'b0, pfail_wake_i = 1'b0, ext_irq_ack_i = 1'b0, ext_reset_pin_i = 1'b0;
  logic ser_rx_fall_i = 1'b0, xtal_tick_i = 1'b0, ext_exec_i = 1'b0, irq_req = 1'b0;
  logic wdt_req = 1'b0, hreadyout_o, any_irq_i, wdt_reset_i, core_hold_o, core_reset_o;
  logic clocks_run_o, xtal_amp_en_o, ring_osc_en_o, ring_clk_sel_o, addr_latch_en_o;
  logic program_fetch_strobe_o, port2_weak_pull_o, port_bus_hold_o;
  logic brownout_i = 1'b0, por_i = 1'b0, ser_tx_load_i = 1'b0, port0_open_drain_o, hresp_o;
  logic [2:0] active_irq_level_i = 3'h0;
  logic [3:0] ser_active_i = 4'h0;
  logic [7:0] rd;
  logic [7:0] dv [9] = '{8'hC0, 8'h00, 8'h40, 8'h80, 8'h00, 8'hC0, 8'h80, 8'h40, 8'h80};
  logic [7:0] de [9] = '{8'hC0, 8'hC0, 8'hC0, 8'h80, 8'h00, 8'h00, 8'h80, 8'h40, 8'h80};
  localparam logic [7:0] PC = pscc_pkg::ADDR_POWER_CONTROL;
  localparam logic [7:0] PM = pscc_pkg::ADDR_POWER_MGMT;
  int fail_count = 0, total_checks = 0, cycles = 0;

  pscc_ctrl #(.XTAL_SETTLE(16)) DUT (.mclk_i, .rst_n_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i,
    .hsize_i(3'h2), .hwdata_i, .hready_i(hreadyout_o), .hrdata_o, .hreadyout_o, .hresp_o,
    .ext_wake_i, .pfail_wake_i, .any_irq_i, .ext_irq_ack_i, .ext_reset_pin_i, .brownout_i,
    .por_i, .wdt_reset_i, .active_irq_level_i, .ser_active_i, .ser_rx_fall_i,
    .ser_tx_load_i, .xtal_tick_i, .ext_exec_i, .core_hold_o, .core_reset_o, .clocks_run_o,
    .xtal_amp_en_o, .ring_osc_en_o, .ring_clk_sel_o, .divider_sel_o, .addr_latch_en_o,
    .program_fetch_strobe_o, .port0_open_drain_o, .port2_weak_pull_o, .port_bus_hold_o);
  pscc_core_model u_core (.mclk_i, .irq_req_i(irq_req), .wdt_req_i(wdt_req),
    .any_irq_o(any_irq_i), .wdt_reset_o(wdt_reset_i));

  initial forever #10 mclk_i = ~mclk_i;

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // one single word transfer: address phase, then data phase
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    hsel_i <= 1'b1;
    htrans_i <= 2'h2;
    hwrite_i <= w;
    haddr_i <= {24'h0, a};
    do @(posedge mclk_i); while (hreadyout_o !== 1'b1);
    hsel_i <= 1'b0;
    htrans_i <= 2'h0;
    hwdata_i <= {24'h0, d};
    do @(posedge mclk_i); while (hreadyout_o !== 1'b1);
    rd = hrdata_o[7:0];
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    bus(1'b0, a, 8'h00);
    chk(rd, exp);
    chk({7'h0, hresp_o}, 8'h00);
  endtask

  task automatic wait_hold(input logic v);
    int n = 0;
    while (core_hold_o !== v && n < 40) begin
      @(posedge mclk_i);
      n++;
    end
    chk({7'h0, core_hold_o}, {7'h0, v});
  endtask

  task automatic pulse_sw(input int k);
    @(posedge mclk_i);
    if (k == 0) ext_irq_ack_i <= 1'b1;
    else if (k == 1) ser_rx_fall_i <= 1'b1;
    else ser_tx_load_i <= 1'b1;
    @(posedge mclk_i);
    ext_irq_ack_i <= 1'b0;
    ser_rx_fall_i <= 1'b0;
    ser_tx_load_i <= 1'b0;
  endtask

  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge mclk_i);
      xtal_tick_i <= 1'b1;
      @(posedge mclk_i);
      xtal_tick_i <= 1'b0;
    end
  endtask

  // k selects the source: 0 reset pin, 1 brownout, 2 power-on
  task automatic pin_reset(input int k);
    if (k == 0) ext_reset_pin_i <= 1'b1;
    else if (k == 1) brownout_i <= 1'b1;
    else por_i <= 1'b1;
    repeat (8) @(posedge mclk_i);
    chk({7'h0, core_reset_o}, 8'h01);
    ext_reset_pin_i <= 1'b0;
    brownout_i <= 1'b0;
    por_i <= 1'b0;
    wait_hold(1'b0);
    repeat (8) @(posedge mclk_i);
  endtask

  initial begin
    repeat (20) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    rdchk(PC, 8'h00);
    rdchk(PM, 8'h80);
    rdchk(pscc_pkg::ADDR_POWER_STATUS, 8'h00);
    rdchk(8'h40, 8'h00);
    foreach (dv[i]) begin
      bus(1'b1, PM, dv[i]);
      rdchk(PM, de[i]);
      chk({6'h0, divider_sel_o}, {6'h0, de[i][7:6]});
    end
    for (int k = 0; k < 3; k++) begin
      bus(1'b1, PM, 8'hC0);
      pulse_sw(k);
      rdchk(PM, 8'hC0);
      bus(1'b1, PM, 8'hE0);
      pulse_sw(k);
      rdchk(PM, 8'hA0);
    end
    for (int l = 0; l < 6; l++) begin
      active_irq_level_i <= l[2:0];
      ser_active_i <= ~l[3:0];
      rdchk(pscc_pkg::ADDR_POWER_STATUS, {l[2:0], 1'b0, ~l[3:0]});
    end
    $display("test registers done");
    ext_exec_i <= 1'b1;
    bus(1'b1, PC, 8'h01);
    wait_hold(1'b1);
    chk({6'h0, clocks_run_o, port0_open_drain_o}, 8'h02);
    chk({5'h0, port_bus_hold_o, addr_latch_en_o, program_fetch_strobe_o}, 8'h07);
    irq_req <= 1'b1;
    wait_hold(1'b0);
    irq_req <= 1'b0;
    ext_exec_i <= 1'b0;
    rdchk(PC, 8'h00);
    bus(1'b1, PC, 8'h01);
    wait_hold(1'b1);
    pin_reset(0);
    $display("test idle done");
    bus(1'b1, PC, 8'h03);
    wait_hold(1'b1);
    irq_req <= 1'b1;
    wdt_req <= 1'b1;
    pfail_wake_i <= 1'b1;
    brownout_i <= 1'b1;
    repeat (12) @(posedge mclk_i);
    chk({6'h0, clocks_run_o, xtal_amp_en_o}, 8'h00);
    chk({5'h0, port0_open_drain_o, port2_weak_pull_o, core_hold_o}, 8'h07);
    irq_req <= 1'b0;
    wdt_req <= 1'b0;
    pfail_wake_i <= 1'b0;
    brownout_i <= 1'b0;
    ext_wake_i <= 1'b1;
    wait_hold(1'b0);
    ext_wake_i <= 1'b0;
    $display("test stop done");
    bus(1'b1, pscc_pkg::ADDR_WAKE_CONFIG, 8'h03);
    bus(1'b1, PC, 8'h02);
    wait_hold(1'b1);
    pfail_wake_i <= 1'b1;
    wait_hold(1'b0);
    pfail_wake_i <= 1'b0;
    chk({7'h0, ring_clk_sel_o}, 8'h01);
    // let the wake level drain out of the synchroniser before stopping again
    repeat (4) @(posedge mclk_i);
    bus(1'b1, PC, 8'h02);
    wait_hold(1'b1);
    chk({6'h0, ring_osc_en_o, xtal_amp_en_o}, 8'h00);
    ext_wake_i <= 1'b1;
    wait_hold(1'b0);
    ext_wake_i <= 1'b0;
    ticks(15);
    chk({7'h0, ring_clk_sel_o}, 8'h01);
    ticks(3);
    repeat (3) @(posedge mclk_i);
    chk({7'h0, ring_clk_sel_o}, 8'h00);
    bus(1'b1, PC, 8'h02);
    wait_hold(1'b1);
    pin_reset(0);
    bus(1'b1, PC, 8'h02);
    wait_hold(1'b1);
    pin_reset(1);
    rdchk(pscc_pkg::ADDR_WAKE_CONFIG, 8'h03);
    pin_reset(2);
    rdchk(pscc_pkg::ADDR_WAKE_CONFIG, 8'h00);
    $display("test ring done");
    tally_and_finish();
  end
endmodule // tb
